//--- pkg/sgmt_cfg.svh
// Constants for the signal measurement timer: widths, mode codes, reset values
`ifndef SGMT_CFG_SVH
`define SGMT_CFG_SVH

`define SGMT_CNT_W 24
`define SGMT_MODE_W 4
`define SGMT_CNT_RST 24'h00_0000
`define SGMT_CNT_ONE 24'h00_0001

`define SGMT_MODE_TIMER 4'h0
`define SGMT_MODE_GATED 4'h1
`define SGMT_MODE_TOF 4'h6
`define SGMT_MODE_CAPTURE 4'h7
`define SGMT_MODE_COUNTER 4'h8
`define SGMT_MODE_GCOUNTER 4'h9
`define SGMT_MODE_WCOUNTER 4'hA
`define SGMT_MODE_FIRST_RSVD 4'hB

`endif

//--- pkg/sgmt_pkg.sv
// Types shared by the signal measurement timer
package sgmt_pkg;

   typedef struct packed {
      logic [3:0] mode;
      logic repeat_en;
      logic window_polarity;
      logic signal_polarity;
      logic timer_clock_polarity;
      logic timer_clock_sel;
   } sgmt_cfg_t;

   typedef struct packed {
      logic run_status_flag;
      logic go_control_bit;
      logic period_match;
      logic period_capture_upd;
      logic pulse_width_capture_upd;
   } sgmt_stat_t;

   typedef enum {
      SGMT_TOF_WAIT,
      SGMT_TOF_TIME
   } sgmt_tof_t;

endpackage : sgmt_pkg

//--- rtl/sgmt_top.sv
// Signal measurement timer: timer, time-of-flight, capture and counter modes
//
// Functional notes
// - Run flag follows go, lagging in synchronous modes
// - Polarity bit set inverts window, signal, clock
// - Single acquisition stops counter and clears go
// - Repeat keeps go set; new results overwrite old
// - Four-bit mode code selects the operation
// - Timer mode counts each timer clock while go
// - Timer counting follows the selected timer clock
// - Count equal to period resets it, flags match
// - Flight timing starts on window rising edge
// - In flight timing, signal rise captures period and resets the count; capture mode keeps counting
// - Second window rise captures pulse width, resets
`timescale 1ns/1ns
`include "sgmt_cfg.svh"

module sgmt_top (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire sgmt_pkg::sgmt_cfg_t i_cfg,
   input wire logic i_go_set,
   input wire logic i_go_clr,
   input wire logic [`SGMT_CNT_W-1:0] i_period_value,
   input wire logic i_measured_signal_input,
   input wire logic i_window_input,
   input wire logic i_timer_clock,
   output logic [`SGMT_CNT_W-1:0] o_count_value,
   output logic [`SGMT_CNT_W-1:0] o_period_capture,
   output logic [`SGMT_CNT_W-1:0] o_pulse_width_capture,
   output sgmt_pkg::sgmt_stat_t o_status
);

   function automatic logic rise_of(input logic cur, input logic prev);
      rise_of = cur & ~prev;
   endfunction : rise_of

   logic [`SGMT_CNT_W-1:0] count_q;
   logic [`SGMT_CNT_W-1:0] count_d;
   logic [`SGMT_CNT_W-1:0] cpr_q;
   logic [`SGMT_CNT_W-1:0] cpw_q;
   logic go_q;
   logic go_d;
   logic run_lag_q;
   logic sig_prev_q;
   logic win_prev_q;
   logic tclk_prev_q;
   sgmt_pkg::sgmt_tof_t tof_q;
   sgmt_pkg::sgmt_tof_t tof_d;
   sgmt_pkg::sgmt_stat_t stat_d;

   // Inputs after polarity selection
   wire measured_signal_internal = i_measured_signal_input ^ i_cfg.signal_polarity;
   wire window_internal = i_window_input ^ i_cfg.window_polarity;
   wire timer_clock_internal = i_timer_clock ^ i_cfg.timer_clock_polarity;

   wire sig_rise = rise_of(measured_signal_internal, sig_prev_q);
   wire win_rise = rise_of(window_internal, win_prev_q);
   // Timer clock: every reference cycle, or each rising edge of the external source after polarity selection
   wire tick = i_cfg.timer_clock_sel ? rise_of(timer_clock_internal, tclk_prev_q) : 1'b1;

   // Mode decode
   wire m_timer = (i_cfg.mode == `SGMT_MODE_TIMER);
   wire m_gated = (i_cfg.mode == `SGMT_MODE_GATED);
   wire m_tof = (i_cfg.mode == `SGMT_MODE_TOF);
   wire m_capture = (i_cfg.mode == `SGMT_MODE_CAPTURE);
   wire m_counter = (i_cfg.mode == `SGMT_MODE_COUNTER);
   wire m_gcounter = (i_cfg.mode == `SGMT_MODE_GCOUNTER) || (i_cfg.mode == `SGMT_MODE_WCOUNTER);
   wire m_rsvd = (i_cfg.mode >= `SGMT_MODE_FIRST_RSVD);
   wire m_async = m_counter || m_gcounter;
   wire m_plain = !m_gated && !m_tof && !m_async && !m_rsvd;

   wire tof_timing = (tof_q == sgmt_pkg::SGMT_TOF_TIME);
   wire tof_start = go_q && m_tof && !tof_timing && win_rise;
   wire tof_sig_cap = go_q && m_tof && tof_timing && sig_rise;
   wire tof_win_cap = go_q && m_tof && tof_timing && win_rise && !sig_rise;
   wire cap_event = go_q && m_capture && sig_rise;
   wire acq_done = tof_sig_cap || tof_win_cap || cap_event;

   // Counting enable per mode; reserved modes never count
   wire cnt_en = go_q && ((m_plain && tick) ||
                          (m_gated && tick && window_internal) ||
                          (m_tof && tick && tof_timing) ||
                          (m_counter && sig_rise) ||
                          (m_gcounter && sig_rise && window_internal));
   wire match = cnt_en && (count_q == i_period_value);

   always_comb begin
      if (tof_sig_cap || tof_win_cap || tof_start || match) begin
         count_d = `SGMT_CNT_RST;
      end else if (cnt_en) begin
         count_d = count_q + `SGMT_CNT_ONE;
      end else begin
         count_d = count_q;
      end
   end

   // Software set wins over any clear in the same cycle
   assign go_d = i_go_set || (go_q && !i_go_clr && !(acq_done && !i_cfg.repeat_en));

   always_comb begin
      tof_d = tof_q;
      if (!go_q || !m_tof) begin
         tof_d = sgmt_pkg::SGMT_TOF_WAIT;
      end else if (tof_start) begin
         tof_d = sgmt_pkg::SGMT_TOF_TIME;
      end else if (tof_sig_cap) begin
         tof_d = sgmt_pkg::SGMT_TOF_WAIT;
      end
   end

   always_comb begin
      stat_d.go_control_bit = go_d;
      // Counter modes report directly; synchronous modes add one stage of lag
      stat_d.run_status_flag = m_async ? go_q : run_lag_q;
      stat_d.period_match = match;
      stat_d.period_capture_upd = tof_sig_cap || cap_event;
      stat_d.pulse_width_capture_upd = tof_win_cap;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         sig_prev_q <= 1'b0;
         win_prev_q <= 1'b0;
         tclk_prev_q <= 1'b0;
      end else begin
         sig_prev_q <= measured_signal_internal;
         win_prev_q <= window_internal;
         tclk_prev_q <= timer_clock_internal;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         count_q <= `SGMT_CNT_RST;
         go_q <= 1'b0;
         run_lag_q <= 1'b0;
         tof_q <= sgmt_pkg::SGMT_TOF_WAIT;
         o_status <= '0;
      end else begin
         count_q <= count_d;
         go_q <= go_d;
         run_lag_q <= go_q;
         tof_q <= tof_d;
         o_status <= stat_d;
      end
   end

   // Later acquisitions overwrite earlier results
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         cpr_q <= `SGMT_CNT_RST;
         cpw_q <= `SGMT_CNT_RST;
      end else begin
         if (tof_sig_cap || cap_event) begin
            cpr_q <= count_q;
         end
         if (tof_win_cap) begin
            cpw_q <= count_q;
         end
      end
   end

   assign o_count_value = count_q;
   assign o_period_capture = cpr_q;
   assign o_pulse_width_capture = cpw_q;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   sequence s_tof_armed;
      go_q && m_tof && !tof_timing && win_rise;
   endsequence

   sequence s_tof_signal;
      go_q && m_tof && tof_timing && sig_rise;
   endsequence

   sequence s_tof_window_again;
      go_q && m_tof && tof_timing && win_rise && !sig_rise;
   endsequence

   sequence s_single_done;
      acq_done && !i_cfg.repeat_en && !i_go_set;
   endsequence

   chk_run_lag: assert property (go_q ##1 !m_async |=> o_status.run_status_flag)
      else $error("run flag did not follow go after two cycles");

   chk_pol_window: assert property (go_q && m_tof && !tof_timing && !win_prev_q &&
                                    (i_window_input != i_cfg.window_polarity) |=> tof_timing)
      else $error("polarised window edge did not start timing");

   chk_single_stop: assert property (s_single_done
                                     |=> !go_q && !o_status.go_control_bit)
      else $error("single acquisition did not clear go");

   chk_repeat_keep: assert property (acq_done && i_cfg.repeat_en && !i_go_clr |=> go_q)
      else $error("repeat acquisition stopped the timer");

   chk_rsvd_idle: assert property (m_rsvd |=> $stable(count_q) && !o_status.period_match
                                   && !o_status.period_capture_upd)
      else $error("reserved mode changed timer state");

   chk_timer_inc: assert property (go_q && m_timer && tick && (count_q != i_period_value)
                                   |=> count_q == $past(count_q) + `SGMT_CNT_ONE)
      else $error("timer mode did not increment");

   chk_tick_gate: assert property (go_q && m_timer && !tick |=> $stable(count_q))
      else $error("timer counted without a timer clock edge");

   chk_period_match: assert property (cnt_en && (count_q == i_period_value)
                                      |=> count_q == `SGMT_CNT_RST && o_status.period_match)
      else $error("period match did not reset count and flag");

   chk_tof_start: assert property (s_tof_armed |=> tof_timing && count_q == `SGMT_CNT_RST)
      else $error("flight timing did not start on window edge");

   chk_tof_period: assert property (s_tof_signal
                                    |=> o_period_capture == $past(count_q) && count_q == `SGMT_CNT_RST && !tof_timing)
      else $error("signal edge did not capture and reset");

   chk_tof_width: assert property (s_tof_window_again
                                   |=> o_pulse_width_capture == $past(count_q) && count_q == `SGMT_CNT_RST)
      else $error("second window edge did not capture width");

   chk_mode_async: assert property (m_counter && go_q && !sig_rise |=> $stable(count_q))
      else $error("counter mode counted without a signal edge");

   chk_run_direct: assert property (m_async
                                    |=> o_status.run_status_flag == $past(go_q))
      else $error("counter mode run flag did not follow go");

   chk_run_follow: assert property (!m_async ##1 !m_async
                                    |=> o_status.run_status_flag == $past(go_q, 2))
      else $error("run flag lag in synchronous mode is wrong");

   chk_go_set: assert property (i_go_set
                                |=> go_q && o_status.go_control_bit)
      else $error("software set did not start the timer");

   chk_go_clear: assert property (i_go_clr && !i_go_set
                                  |=> !go_q && !o_status.go_control_bit)
      else $error("software clear did not stop the timer");

   chk_timer_go: assert property (m_timer && !i_go_set && !i_go_clr
                                  |=> go_q == $past(go_q))
      else $error("timer mode changed go without software");

   chk_single_halt: assert property (s_single_done
                                     |-> ##2 $stable(count_q))
      else $error("count kept running after single acquisition");

   chk_sig_pol: assert property (go_q && m_tof && tof_timing && !sig_prev_q &&
                                 (i_measured_signal_input != i_cfg.signal_polarity) |=> !tof_timing)
      else $error("polarised signal edge did not end timing");

   chk_clk_pol: assert property (go_q && m_timer && i_cfg.timer_clock_sel && !tclk_prev_q &&
                                 (i_timer_clock != i_cfg.timer_clock_polarity) && (count_q != i_period_value)
                                 |=> count_q == $past(count_q) + `SGMT_CNT_ONE)
      else $error("polarised timer clock edge did not count");

   chk_match_pulse: assert property (o_status.period_match
                                     |-> $past(count_q) == $past(i_period_value) && count_q == `SGMT_CNT_RST)
      else $error("period match flag without an equal count");

   chk_match_gate: assert property (!cnt_en
                                    |=> !o_status.period_match)
      else $error("period match flag while not counting");

   chk_tof_wait: assert property (go_q && m_tof && !tof_timing && !win_rise
                                  |=> $stable(count_q) && !tof_timing)
      else $error("flight timing ran before a window edge");

   chk_tof_idle: assert property (!go_q
                                  |=> !tof_timing)
      else $error("flight timing active while stopped");

   chk_tof_count: assert property (go_q && m_tof && tof_timing && tick && !win_rise && !sig_rise &&
                                   (count_q != i_period_value) |=> count_q == $past(count_q) + `SGMT_CNT_ONE)
      else $error("flight timing did not increment");

   chk_period_upd: assert property (s_tof_signal
                                    |=> o_status.period_capture_upd && !o_status.pulse_width_capture_upd)
      else $error("signal edge did not flag a period capture");

   chk_period_hold: assert property (!(tof_sig_cap || cap_event)
                                     |=> $stable(o_period_capture))
      else $error("period capture changed without an acquisition");

   chk_width_upd: assert property (s_tof_window_again
                                   |=> o_status.pulse_width_capture_upd && tof_timing)
      else $error("second window edge did not flag a width capture");

   chk_width_hold: assert property (!tof_win_cap
                                    |=> $stable(o_pulse_width_capture))
      else $error("width capture changed without a window edge");

   chk_rsvd_capture: assert property (m_rsvd
                                      |=> !o_status.pulse_width_capture_upd && $stable(o_period_capture) &&
                                      $stable(o_pulse_width_capture))
      else $error("reserved mode captured a value");

   chk_counter_inc: assert property (go_q && m_counter && sig_rise && (count_q != i_period_value)
                                     |=> count_q == $past(count_q) + `SGMT_CNT_ONE)
      else $error("counter mode missed a signal edge");

endmodule : sgmt_top

//--- bench/sgmt_src.sv
// Model of the window, measured signal and timer clock sources
`timescale 1ns/1ns
module sgmt_src (
   input wire logic i_ref_clk,
   output logic o_window,
   output logic o_signal,
   output logic o_tclk
);
   initial begin
      o_window = 1'b0;
      o_signal = 1'b0;
      o_tclk = 1'b0;
   end
   // Levels change only just after a falling edge
   task drive(input logic w, input logic s, input logic t);
      @(negedge i_ref_clk);
      o_window = w;
      o_signal = s;
      o_tclk = t;
   endtask : drive
endmodule : sgmt_src

//--- bench/test_sgmt_top.sv
// Self-checking bench for the signal measurement timer
`timescale 1ns/1ns
`include "sgmt_cfg.svh"
`define SG_CHK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) begin \
         failures++; \
         $display("unexpected at %0t: got %h expected %h", $time, g, e); \
      end \
   end
module test_sgmt_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic go_s = 1'b0;
   logic go_c = 1'b0;
   logic win, sig, tck;
   logic [23:0] per = 24'h00_0002;
   logic [23:0] cnt, cpr, cpw, c;
   sgmt_pkg::sgmt_cfg_t cfg = '0;
   sgmt_pkg::sgmt_stat_t st;
   int failures = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   always #50 clk = ~clk;
   sgmt_src src (.i_ref_clk(clk), .o_window(win), .o_signal(sig), .o_tclk(tck));
   sgmt_top uut (.i_ref_clk(clk), .i_srst(srst), .i_cfg(cfg), .i_go_set(go_s), .i_go_clr(go_c),
      .i_period_value(per), .i_measured_signal_input(sig), .i_window_input(win), .i_timer_clock(tck),
      .o_count_value(cnt), .o_period_capture(cpr), .o_pulse_width_capture(cpw), .o_status(st));
   task end_sim;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   task go(input logic s, input logic k);
      @(negedge clk);
      go_s = s;
      go_c = k;
      @(negedge clk);
      go_s = 1'b0;
      go_c = 1'b0;
   endtask : go
   task wait_bit(input int b, output int m);
      m = 0;
      do begin
         @(negedge clk);
         m++;
      end while (st[b] !== 1'b1 && m < 50);
   endtask : wait_bit
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      repeat (20) @(negedge clk);
      `SG_CHK(st, 5'h00)
      srst = 1'b0;
      go(1'b1, 1'b0);
      wait_bit(2, n);
      `SG_CHK(cnt, 24'h00_0000)
      `SG_CHK(st.run_status_flag, 1'b1)
      wait_bit(2, n);
      `SG_CHK(n, 3)
      `SG_CHK(st.go_control_bit, 1'b1)
      go(1'b0, 1'b1);
      repeat (2) @(negedge clk);
      c = cnt;
      @(negedge clk);
      `SG_CHK(cnt, c)
      `SG_CHK(st[4:3], 2'h0)
      // Timer clock input as tick source
      per = 24'h00_0010;
      cfg.timer_clock_sel = 1'b1;
      go(1'b1, 1'b0);
      c = cnt;
      repeat (3) @(negedge clk);
      `SG_CHK(cnt, c)
      src.drive(1'b0, 1'b0, 1'b1);
      src.drive(1'b0, 1'b0, 1'b0);
      @(negedge clk);
      `SG_CHK(cnt, c + 24'h00_0001)
      go(1'b0, 1'b1);
      // Single flight measurement
      cfg.timer_clock_sel = 1'b0;
      cfg.mode = `SGMT_MODE_TOF;
      go(1'b1, 1'b0);
      repeat (5) src.drive(1'b1, 1'b0, 1'b0);
      src.drive(1'b1, 1'b1, 1'b0);
      @(negedge clk);
      `SG_CHK(cpr, 24'h00_0004)
      `SG_CHK(st.period_capture_upd, 1'b1)
      @(negedge clk);
      `SG_CHK(st.go_control_bit, 1'b0)
      // Repeated flight measurement with inverted window
      cfg.repeat_en = 1'b1;
      cfg.window_polarity = 1'b1;
      go(1'b1, 1'b0);
      repeat (4) src.drive(1'b0, 1'b0, 1'b0);
      src.drive(1'b1, 1'b0, 1'b0);
      src.drive(1'b0, 1'b0, 1'b0);
      @(negedge clk);
      `SG_CHK(cpw, 24'h00_0004)
      `SG_CHK(st.pulse_width_capture_upd, 1'b1)
      src.drive(1'b0, 1'b0, 1'b0);
      src.drive(1'b0, 1'b1, 1'b0);
      @(negedge clk);
      `SG_CHK(cpr, 24'h00_0002)
      @(negedge clk);
      `SG_CHK(st.go_control_bit, 1'b1)
      // Reserved code holds the count and raises no match or capture flags
      cfg.mode = `SGMT_MODE_FIRST_RSVD;
      @(negedge clk);
      c = cnt;
      src.drive(1'b1, 1'b0, 1'b1);
      src.drive(1'b0, 1'b0, 1'b0);
      repeat (3) @(negedge clk);
      `SG_CHK(cnt, c)
      `SG_CHK(st[2:0], 3'h0)
      // Counter mode with inverted signal counts falling input edges
      src.drive(1'b0, 1'b1, 1'b0);
      cfg.mode = `SGMT_MODE_COUNTER;
      cfg.signal_polarity = 1'b1;
      c = cnt;
      repeat (2) begin
         src.drive(1'b0, 1'b0, 1'b0);
         src.drive(1'b0, 1'b1, 1'b0);
      end
      @(negedge clk);
      `SG_CHK(cnt, c + 24'h00_0002)
      `SG_CHK(st.run_status_flag, 1'b1)
      go(1'b0, 1'b1);
      @(negedge clk);
      `SG_CHK(st[4:3], 2'h0)
      // Single capture stops the count and clears go
      cfg.mode = `SGMT_MODE_CAPTURE;
      cfg.repeat_en = 1'b0;
      go(1'b1, 1'b0);
      c = cnt;
      src.drive(1'b0, 1'b0, 1'b0);
      @(negedge clk);
      `SG_CHK(cpr, c + 24'h00_0001)
      `SG_CHK(st[3:1], 3'h1)
      @(negedge clk);
      `SG_CHK(cnt, c + 24'h00_0002)
      end_sim();
   end
endmodule : test_sgmt_top
